// ==== press_monitor_defines.vh ====
// Purpose: shared constants for the press stop/start monitor
// Assumes: 20 MHz system clock
// Notes:   times in ms, minutes and seconds, counts derived here
`ifndef PRESS_MONITOR_DEFINES_VH
`define PRESS_MONITOR_DEFINES_VH
`define CLK_HZ            20000000
`define MS_PER_S          10'd1000
`define TICK_MS           1
`define CYC_PER_MS        ((`CLK_HZ / `MS_PER_S) * `TICK_MS)
`define STOP_LIMIT_DEF    16'd500
`define START_LIMIT_DEF   16'd1998
`define WARN_MARGIN_MS    16'd10
`define SHUTDOWN_MAX_MIN  7'd100
`define SHUTDOWN_DEF_MIN  7'd3
`define MS_PER_MIN        32'd60000
`define FLY_DEF_S         8'd15
`define ANGLE_DEF         9'h000
`define ANGLE_LO_MAX      9'd30
`define ANGLE_HI_MIN      9'd330
`define ANGLE_TOP         9'd359
`define UNIT_PSI          2'd0
`define UNIT_KPA          2'd1
`define UNIT_BAR          2'd2
`define UNIT_DEF          2'd1
`define FLASH_HALF_MS     16'd250
`endif

// ==== press_stop_start_monitor.v ====
// Purpose: brake stop-time, start-time, shutdown and flywheel supervision
// Assumes: all inputs but arst_n synchronous to clk; key inputs are one-cycle pulses
// Notes:   limits held here, loaded from operator entry pulses, initialization and the first stroke
`timescale 1ns/1ps
`default_nettype none
`include "press_monitor_defines.vh"

// What this block does
// (RULE1) Time valve release until crank at rest
// (RULE2) Flash brake warning within 10 ms
// (RULE3) Over stop limit: fault, inhibit until cleared
// (RULE4) Initialization loads stop limit 500 ms
// (RULE5) Time relay close until first rotation
// (RULE6) Over start limit: rotation fault, no start
// (RULE7) Initialization loads start limit 1998 ms
// (RULE8) First stroke sets start limit twice measured
// (RULE9) Operator override should exceed 40 percent margin; code loads any entered start limit unchecked
// (RULE10) Stop limit set 10 ms above normal; code loads stop limit only from entry or the 500 ms default
// (RULE11) Shutdown timer opens lockout relay on expiry
// (RULE12) Shutdown settings 0 to 100 minutes accepted
// (RULE13) Show motor shutdown fault after shutdown
// (RULE14) Shutdown timer only with compensated top-stop
// (RULE15) Measure flywheel revolution period from sensor
// (RULE16) Short period blocks reversal and bar mode
// (RULE17) Interlock covers both direction changes
// (RULE18) Accept top-stop angle 330 through 30 only
// (RULE19) Top-stop angle defaults to zero degrees
// (RULE20) Three pressure units, limits in selected unit; code holds no pressure limits
// (RULE21) Enter key cycles pressure unit selection
// (RULE22) Initialization restores all parameters to defaults
// (RULE23) Enter confirms initialization, reset key cancels
// (RULE24) Millisecond counters sized for largest limit
module press_stop_start_monitor #(
    parameter integer CYC_PER_MS = `CYC_PER_MS,
    parameter integer TW         = 16
) (
    input  wire          clk,
    input  wire          arst_n,
    input  wire          safety_valve_drive,
    input  wire          crank_moving,
    input  wire          speed_comp_top_stop,
    input  wire          flywheel_pulse,
    input  wire          fault_clear,
    input  wire          stop_limit_wr,
    input  wire          start_limit_wr,
    input  wire [TW-1:0] limit_value,
    input  wire          shutdown_wr,
    input  wire [6:0]    shutdown_value,
    input  wire          flywheel_wr,
    input  wire [7:0]    flywheel_value,
    input  wire          angle_wr,
    input  wire [8:0]    angle_value,
    input  wire          unit_enter,
    input  wire          init_request,
    input  wire          enter_key,
    input  wire          reset_key,
    input  wire          reverse_request,
    input  wire          bar_request,
    output reg  [TW-1:0] stop_limit,
    output reg  [TW-1:0] start_limit,
    output reg  [TW-1:0] last_stop_time,
    output reg  [TW-1:0] last_start_time,
    output reg  [6:0]    shutdown_minutes,
    output reg  [7:0]    flywheel_seconds,
    output reg  [8:0]    top_stop_angle,
    output reg  [1:0]    pressure_unit,
    output reg           angle_rejected,
    output reg           init_pending,
    output reg           brake_wear_indicator,
    output reg           stop_limit_fault,
    output reg           rotation_loss_fault,
    output reg           motor_shutdown_fault,
    output reg           lockout_relay_closed,
    output reg           press_inhibit,
    output reg           reverse_grant,
    output reg           bar_grant,
    output reg           flywheel_fast
);

    // Millisecond tick divider; one pulse per ms
    reg [24:0] div_count;
    reg        ms_tick;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_count <= 25'h0000000;
            ms_tick   <= 1'b0;
        end else if (div_count == CYC_PER_MS - 1) begin
            div_count <= 25'h0000000;
            ms_tick   <= 1'b1;
        end else begin
            div_count <= div_count + 25'h0000001;
            ms_tick   <= 1'b0;
        end
    end

    // Edge history of valve, motion and flywheel inputs
    reg valve_d;
    reg moving_d;
    reg fly_d;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            valve_d  <= 1'b0;
            moving_d <= 1'b0;
            fly_d    <= 1'b0;
        end else begin
            valve_d  <= safety_valve_drive;
            moving_d <= crank_moving;
            fly_d    <= flywheel_pulse;
        end
    end
    wire valve_on   = safety_valve_drive & ~valve_d;
    wire valve_off  = ~safety_valve_drive & valve_d;
    wire fly_edge   = flywheel_pulse & ~fly_d;
    wire init_do    = init_pending & enter_key;   // see (RULE23)

    // Stop and start timing, valve release to crank at rest and valve on to first rotation
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_STOP = 2'd1;
    localparam [1:0] ST_START = 2'd2;
    localparam [1:0] ST_RUN = 2'd3;
    reg [1:0]    state;
    reg [TW-1:0] meas;
    reg          first_stroke;
    // Saturate so a stuck input never wraps back under the limit
    wire [TW-1:0] meas_inc = (meas == {TW{1'b1}}) ? meas :
                             meas + {{(TW-1){1'b0}}, 1'b1}; // see (RULE24)
    wire [TW:0]   twice    = {meas, 1'b0};
    wire [TW-1:0] warn_lvl = (stop_limit > `WARN_MARGIN_MS) ?
                             stop_limit - `WARN_MARGIN_MS : {TW{1'b0}};
    reg           warn_on;

    // Measurement state machine and fault flags
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state               <= ST_IDLE;
            meas                <= {TW{1'b0}};
            last_stop_time      <= {TW{1'b0}};
            last_start_time     <= {TW{1'b0}};
            stop_limit          <= `STOP_LIMIT_DEF;
            start_limit         <= `START_LIMIT_DEF;
            first_stroke        <= 1'b1;
            stop_limit_fault    <= 1'b0;
            rotation_loss_fault <= 1'b0;
            warn_on             <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (valve_on) begin
                        meas  <= {TW{1'b0}};
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (!safety_valve_drive) begin
                        state <= ST_IDLE;
                    end else if (crank_moving && !moving_d) begin
                        last_start_time <= meas;         // see (RULE5)
                        if (first_stroke) begin
                            // Saturate doubled value at full scale
                            start_limit <= twice[TW] ? {TW{1'b1}} :
                                           twice[TW-1:0]; // see (RULE8)
                            first_stroke <= 1'b0;
                        end
                        state <= ST_RUN;
                    end else if (ms_tick) begin
                        meas <= meas_inc;
                        if (!first_stroke && meas_inc > start_limit) begin
                            rotation_loss_fault <= 1'b1; // see (RULE6)
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_RUN: begin
                    if (valve_off) begin
                        meas  <= {TW{1'b0}};
                        state <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (!crank_moving) begin
                        last_stop_time <= meas;          // see (RULE1)
                        warn_on <= (meas >= warn_lvl);   // see (RULE2)
                        if (meas > stop_limit) begin
                            stop_limit_fault <= 1'b1;    // see (RULE3)
                        end
                        state <= ST_IDLE;
                    end else if (ms_tick) begin
                        meas <= meas_inc;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Clear only when no new fault arrives in the same cycle
            if (fault_clear && !(state == ST_STOP && !crank_moving &&
                                 meas > stop_limit)) begin
                stop_limit_fault <= 1'b0;
            end
            if (fault_clear && !(state == ST_START && ms_tick &&
                                 !first_stroke && meas_inc > start_limit))
            begin
                rotation_loss_fault <= 1'b0;
            end
            if (stop_limit_wr) begin
                stop_limit <= limit_value;
            end
            if (start_limit_wr) begin
                start_limit  <= limit_value;
                first_stroke <= 1'b0;
            end
            if (init_do) begin
                stop_limit   <= `STOP_LIMIT_DEF;     // see (RULE4)
                start_limit  <= `START_LIMIT_DEF;    // see (RULE7)
                first_stroke <= 1'b1;                // see (RULE22)
                warn_on      <= 1'b0;
            end
        end
    end

    // Brake warning flasher, half period in ms
    reg [TW-1:0] flash_cnt;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_cnt            <= {TW{1'b0}};
            brake_wear_indicator <= 1'b0;
        end else if (!warn_on) begin
            flash_cnt            <= {TW{1'b0}};
            brake_wear_indicator <= 1'b0;
        end else if (ms_tick) begin
            if (flash_cnt == `FLASH_HALF_MS - 16'd1) begin
                flash_cnt            <= {TW{1'b0}};
                brake_wear_indicator <= ~brake_wear_indicator; // see (RULE2)
            end else begin
                flash_cnt <= flash_cnt + {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Motor shutdown timer, armed on valve release
    reg [31:0] shut_ms;
    reg        shut_run;
    wire [31:0] shut_target = {25'h0000000, shutdown_minutes} * `MS_PER_MIN;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shut_ms              <= 32'h00000000;
            shut_run             <= 1'b0;
            lockout_relay_closed <= 1'b1;
            motor_shutdown_fault <= 1'b0;
        end else if (!speed_comp_top_stop) begin
            shut_run             <= 1'b0;            // see (RULE14)
            shut_ms              <= 32'h00000000;
            lockout_relay_closed <= 1'b1;
            motor_shutdown_fault <= 1'b0;
        end else begin
            if (safety_valve_drive) begin
                shut_run <= 1'b0;                    // see (RULE11)
                shut_ms  <= 32'h00000000;
            end else if (valve_off) begin
                shut_run <= 1'b1;
                shut_ms  <= 32'h00000000;
            end else if (shut_run) begin
                if (shut_ms >= shut_target) begin
                    shut_run             <= 1'b0;
                    lockout_relay_closed <= 1'b0;    // see (RULE11)
                    motor_shutdown_fault <= 1'b1;    // see (RULE13)
                end else if (ms_tick) begin
                    shut_ms <= shut_ms + 32'h00000001;
                end
            end
            if (fault_clear && !(shut_run && shut_ms >= shut_target)) begin
                lockout_relay_closed <= 1'b1;
                motor_shutdown_fault <= 1'b0;
            end
        end
    end

    // Flywheel period in ms; 18 bits hold a 255 s setting
    reg  [17:0] fly_ms;
    wire [17:0] fly_limit = flywheel_seconds * `MS_PER_S;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fly_ms        <= 18'h00000;
            flywheel_fast <= 1'b1;
        end else if (fly_edge) begin
            flywheel_fast <= (fly_ms < fly_limit);   // see (RULE15)
            fly_ms        <= 18'h00000;
        end else if (ms_tick && fly_ms != 18'h3ffff) begin
            fly_ms <= fly_ms + 18'h00001;
            // No edge yet beyond limit means slow enough
            if (fly_ms >= fly_limit) begin
                flywheel_fast <= 1'b0;
            end
        end
    end

    // Direction change and bar grants, both directions alike
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reverse_grant <= 1'b0;
            bar_grant     <= 1'b0;
            press_inhibit <= 1'b0;
        end else begin
            reverse_grant <= reverse_request & ~flywheel_fast; // see (RULE17)
            bar_grant     <= bar_request & ~flywheel_fast;     // see (RULE16)
            press_inhibit <= stop_limit_fault | rotation_loss_fault; // see (RULE3)
        end
    end

    // Settings: shutdown, flywheel, angle, units, initialization
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdown_minutes <= `SHUTDOWN_DEF_MIN;
            flywheel_seconds <= `FLY_DEF_S;
            top_stop_angle   <= `ANGLE_DEF;
            pressure_unit    <= `UNIT_DEF;
            angle_rejected   <= 1'b0;
            init_pending     <= 1'b0;
        end else begin
            if (shutdown_wr && shutdown_value <= `SHUTDOWN_MAX_MIN) begin
                shutdown_minutes <= shutdown_value;  // see (RULE12)
            end
            if (flywheel_wr) begin
                flywheel_seconds <= flywheel_value;
            end
            if (angle_wr) begin
                if (angle_value <= `ANGLE_LO_MAX ||
                    (angle_value >= `ANGLE_HI_MIN &&
                     angle_value <= `ANGLE_TOP)) begin
                    top_stop_angle <= angle_value;   // see (RULE18)
                    angle_rejected <= 1'b0;
                end else begin
                    angle_rejected <= 1'b1;
                end
            end
            if (unit_enter) begin
                // Cyclic PSI, kPa, bar; see (RULE20)
                pressure_unit <= (pressure_unit == `UNIT_BAR) ?
                                 `UNIT_PSI : pressure_unit + 2'd1; // see (RULE21)
            end
            if (init_request) begin
                init_pending <= 1'b1;
            end else if (init_pending && (enter_key || reset_key)) begin
                init_pending <= 1'b0;                // see (RULE23)
            end
            if (init_do) begin
                shutdown_minutes <= `SHUTDOWN_DEF_MIN;
                flywheel_seconds <= `FLY_DEF_S;
                top_stop_angle   <= `ANGLE_DEF;      // see (RULE19)
                pressure_unit    <= `UNIT_DEF;       // see (RULE22)
                angle_rejected   <= 1'b0;
            end
        end
    end

endmodule // press_stop_start_monitor
`default_nettype wire

// ==== press_monitor_asserts.sv ====
// Purpose: concurrent checks on the press monitor ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every monitor instance below
`timescale 1ns/1ps
`default_nettype none
module press_monitor_asserts #(
    parameter integer CYC_PER_MS = 20000,
    parameter integer TW         = 16
) (
    input wire logic          clk,
    input wire logic          arst_n,
    input wire logic          safety_valve_drive,
    input wire logic          speed_comp_top_stop,
    input wire logic          fault_clear,
    input wire logic          shutdown_wr,
    input wire logic [6:0]    shutdown_value,
    input wire logic          angle_wr,
    input wire logic [8:0]    angle_value,
    input wire logic          unit_enter,
    input wire logic          enter_key,
    input wire logic          reset_key,
    input wire logic          reverse_request,
    input wire logic [TW-1:0] stop_limit,
    input wire logic [TW-1:0] start_limit,
    input wire logic [6:0]    shutdown_minutes,
    input wire logic [8:0]    top_stop_angle,
    input wire logic [1:0]    pressure_unit,
    input wire logic          angle_rejected,
    input wire logic          init_pending,
    input wire logic          stop_limit_fault,
    input wire logic          rotation_loss_fault,
    input wire logic          motor_shutdown_fault,
    input wire logic          lockout_relay_closed,
    input wire logic          press_inhibit,
    input wire logic          reverse_grant,
    input wire logic          flywheel_fast
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Init confirm and cancel steps
    sequence s_init_go;
        init_pending && enter_key;
    endsequence
    sequence s_init_drop;
        init_pending && reset_key && !enter_key;
    endsequence
    sequence s_shut_flag;
        ##[0:1] motor_shutdown_fault;
    endsequence
    property p_init;
        s_init_go |=> stop_limit == 16'h01f4 && start_limit == 16'h07ce
            && top_stop_angle == 9'h000 && pressure_unit == 2'h1;
    endproperty
    a_init: assert property (p_init) else $error("init defaults wrong");
    property p_cancel;
        s_init_drop |=> !init_pending && $stable(stop_limit);
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel changed");
    property p_unit;
        unit_enter && !init_pending |=> pressure_unit ==
            (($past(pressure_unit) == 2'h2) ? 2'h0 : $past(pressure_unit) + 2'h1);
    endproperty
    a_unit: assert property (p_unit) else $error("unit step wrong");
    property p_angle_bad;
        angle_wr && angle_value > 9'h01e && angle_value < 9'h14a
            |=> angle_rejected && $stable(top_stop_angle);
    endproperty
    a_angle_bad: assert property (p_angle_bad) else $error("angle taken");
    property p_angle_ok;
        angle_wr && (angle_value <= 9'h01e || angle_value >= 9'h14a)
            && angle_value <= 9'h167
            |=> !angle_rejected && top_stop_angle == $past(angle_value);
    endproperty
    a_angle_ok: assert property (p_angle_ok) else $error("angle lost");
    property p_shut;
        shutdown_wr && !init_pending |=> shutdown_minutes == ((
            $past(shutdown_value) > 7'h64) ? $past(shutdown_minutes)
            : $past(shutdown_value));
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown setting");
    property p_stop_hold;
        stop_limit_fault && !fault_clear |=> stop_limit_fault;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("fault dropped");
    property p_inhibit;
        1'b1 |=> press_inhibit == $past(stop_limit_fault || rotation_loss_fault);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit wrong");
    property p_lockout;
        $fell(lockout_relay_closed) |-> $past(speed_comp_top_stop)
            && !$past(safety_valve_drive) ##0 s_shut_flag;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout cause");
    property p_rev;
        reverse_grant |-> $past(reverse_request)
            && !$past(flywheel_fast);
    endproperty
    a_rev: assert property (p_rev) else $error("reverse granted");
endmodule // press_monitor_asserts
bind press_stop_start_monitor press_monitor_asserts #(
    .CYC_PER_MS(CYC_PER_MS), .TW(TW)) press_monitor_asserts_i (
    .clk, .arst_n, .safety_valve_drive, .speed_comp_top_stop, .fault_clear,
    .shutdown_wr, .shutdown_value, .angle_wr, .angle_value, .unit_enter,
    .enter_key, .reset_key, .reverse_request, .stop_limit, .start_limit,
    .shutdown_minutes, .top_stop_angle, .pressure_unit, .angle_rejected,
    .init_pending, .stop_limit_fault, .rotation_loss_fault,
    .motor_shutdown_fault, .lockout_relay_closed, .press_inhibit,
    .reverse_grant, .flywheel_fast);
`default_nettype wire

// ==== press_far_side_model.sv ====
// Purpose: valve relays, resolver and flywheel sensor of the press
// Assumes: lags and periods given in clk cycles by the bench
// Notes:   zero flywheel period means a silent sensor
`timescale 1ns/1ps
`default_nettype none
module press_far_side_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        safety_valve_drive,
    input  wire logic [15:0] start_cyc,
    input  wire logic [15:0] stop_cyc,
    input  wire logic [15:0] fly_cyc,
    output var  logic        crank_moving,
    output var  logic        flywheel_pulse
);
    logic [15:0] lag;
    logic [15:0] need;
    logic [15:0] fcnt;
    assign need = safety_valve_drive ? start_cyc : stop_cyc;
    // Crank follows the valve after clutch or brake lag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crank_moving <= 1'b0;
            lag <= 16'h0000;
        end else if (safety_valve_drive == crank_moving) begin
            lag <= 16'h0000;
        end else if (lag + 16'h0001 >= need) begin
            crank_moving <= safety_valve_drive;
            lag <= 16'h0000;
        end else begin
            lag <= lag + 16'h0001;
        end
    end
    // One pulse per flywheel revolution
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fcnt <= 16'h0000;
            flywheel_pulse <= 1'b0;
        end else if (fly_cyc != 16'h0000 && fcnt + 16'h0001 >= fly_cyc) begin
            fcnt <= 16'h0000;
            flywheel_pulse <= 1'b1;
        end else begin
            fcnt <= fcnt + 16'h0001;
            flywheel_pulse <= 1'b0;
        end
    end
endmodule // press_far_side_model
`default_nettype wire

// ==== press_stop_start_monitor_tb_top.sv ====
// Purpose: directed test of the press stop/start monitor
// Assumes: 4 cycles per ms to keep the run short
// Notes:   strobes are one-cycle pulses set at the falling edge
`timescale 1ns/1ps
`default_nettype none
module press_stop_start_monitor_tb_top;
    logic        clk, arst_n, valve, crank, fly, comp, rev_req, bar_req;
    logic [9:0]  stb;
    logic [15:0] val, start_cyc, stop_cyc, fly_cyc;
    logic [15:0] stop_lim, start_lim, last_stop, last_start;
    logic [6:0]  shut_min;
    logic [7:0]  fly_s;
    logic [8:0]  angle;
    logic [1:0]  unit;
    logic        rej, pend, warn, stop_flt, rot_flt, shut_flt, lockout;
    logic        inhibit, rev_gnt, bar_gnt, fast;
    int          bad_count = 0, n_tests = 0, k;
    logic [15:0] av [5] = '{330, 30, 31, 329, 359};
    logic [15:0] ae [5] = '{330, 30, 30, 30, 359};
    press_far_side_model press_far_side_model_i (.clk(clk), .arst_n(arst_n),
        .safety_valve_drive(valve), .start_cyc(start_cyc), .stop_cyc(stop_cyc),
        .fly_cyc(fly_cyc), .crank_moving(crank), .flywheel_pulse(fly));
    press_stop_start_monitor #(.CYC_PER_MS(4)) press_stop_start_monitor_i (
        .clk(clk), .arst_n(arst_n), .safety_valve_drive(valve),
        .crank_moving(crank), .speed_comp_top_stop(comp), .flywheel_pulse(fly),
        .fault_clear(stb[9]), .stop_limit_wr(stb[0]), .start_limit_wr(stb[1]),
        .limit_value(val), .shutdown_wr(stb[2]), .shutdown_value(val[6:0]),
        .flywheel_wr(stb[3]), .flywheel_value(val[7:0]), .angle_wr(stb[4]),
        .angle_value(val[8:0]), .unit_enter(stb[5]), .init_request(stb[6]),
        .enter_key(stb[7]), .reset_key(stb[8]), .reverse_request(rev_req),
        .bar_request(bar_req), .stop_limit(stop_lim), .start_limit(start_lim),
        .last_stop_time(last_stop), .last_start_time(last_start),
        .shutdown_minutes(shut_min), .flywheel_seconds(fly_s),
        .top_stop_angle(angle),
        .pressure_unit(unit), .angle_rejected(rej), .init_pending(pend),
        .brake_wear_indicator(warn), .stop_limit_fault(stop_flt),
        .rotation_loss_fault(rot_flt), .motor_shutdown_fault(shut_flt),
        .lockout_relay_closed(lockout), .press_inhibit(inhibit),
        .reverse_grant(rev_gnt), .bar_grant(bar_gnt), .flywheel_fast(fast));
    // 20 MHz clock
    always #25 clk = ~clk;
    // Tolerance in ms absorbs tick phase and model lag; unknowns fail
    task automatic chk(input string nm, input logic [15:0] e, g,
                       input logic [15:0] tol = 16'h0000);
        n_tests++;
        if ((g + tol >= e && g <= e + tol) !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic op(input int b, input logic [15:0] v);
        @(negedge clk);
        val = v;
        stb[b] = 1'b1;
        @(negedge clk);
        stb = '0;
        repeat (2) @(negedge clk);
    endtask
    // One press stroke with start and stop lags in ms
    task automatic stroke(input int st, input int sp);
        start_cyc = 16'(st * 4);
        stop_cyc = 16'(sp * 4);
        @(negedge clk);
        valve = 1'b1;
        for (k = 0; k < 4000 && crank !== 1'b1; k++) @(negedge clk);
        repeat (40) @(negedge clk);
        valve = 1'b0;
        for (k = 0; k < 4000 && crank !== 1'b0; k++) @(negedge clk);
        repeat (4) @(negedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog well beyond the expected 11k cycles
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        {clk, arst_n, valve, comp, rev_req, bar_req} = '0;
        {stb, val, start_cyc, stop_cyc, fly_cyc} = '0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk("stop_limit", 16'h01f4, stop_lim);
        chk("start_limit", 16'h07ce, start_lim);
        chk("angle", 16'h0000, {7'h00, angle});
        for (int i = 0; i < 3; i++) begin
            op(5, '0);
            chk("unit", 16'((i + 2) % 3), {14'h0, unit});
        end
        for (int i = 0; i < 5; i++) begin
            op(4, av[i]);
            chk("angle", ae[i], {7'h00, angle});
            chk("angle_rej", 16'(i == 2 || i == 3), {15'h0, rej});
        end
        op(2, 16'h0064);
        chk("shutdown", 16'h0064, {9'h0, shut_min});
        op(2, 16'h0065);
        chk("shutdown", 16'h0064, {9'h0, shut_min});
        op(2, 16'h0000);
        chk("shutdown", 16'h0000, {9'h0, shut_min});
        op(0, 16'h0028);
        stroke(50, 20);
        chk("start_time", 16'h0032, last_start, 16'h0002);
        chk("start_limit", 16'h0064, start_lim, 16'h0002);
        chk("stop_time", 16'h0014, last_stop, 16'h0002);
        op(1, 16'h0048);
        chk("start_limit", 16'h0048, start_lim);
        chk("lockout", 16'h0001, {15'h0, lockout});
        stroke(50, 35);
        for (k = 0; k < 2400 && warn !== 1'b1; k++) @(negedge clk);
        chk("brake_warn", 16'h0001, {15'h0, warn});
        chk("stop_fault", 16'h0000, {15'h0, stop_flt});
        stroke(50, 45);
        chk("stop_fault", 16'h0001, {15'h0, stop_flt});
        chk("inhibit", 16'h0001, {15'h0, inhibit});
        op(9, '0);
        chk("stop_fault", 16'h0000, {15'h0, stop_flt});
        stroke(110, 20);
        chk("rot_fault", 16'h0001, {15'h0, rot_flt});
        op(9, '0);
        comp = 1'b1;
        stroke(50, 20);
        chk("lockout", 16'h0000, {15'h0, lockout});
        chk("shut_fault", 16'h0001, {15'h0, shut_flt});
        comp = 1'b0;
        op(3, 16'h0001);
        chk("fly_s", 16'h0001, {8'h00, fly_s});
        fly_cyc = 16'd2000;
        {rev_req, bar_req} = 2'b11;
        repeat (6000) @(negedge clk);
        chk("fast", 16'h0001, {15'h0, fast});
        chk("grants", 16'h0000, {14'h0, rev_gnt, bar_gnt});
        fly_cyc = '0;
        for (k = 0; k < 8000 && fast !== 1'b0; k++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk("grants", 16'h0003, {14'h0, rev_gnt, bar_gnt});
        op(6, '0);
        chk("pending", 16'h0001, {15'h0, pend});
        op(8, '0);
        chk("pending", 16'h0000, {15'h0, pend});
        chk("stop_limit", 16'h0028, stop_lim);
        op(6, '0);
        op(7, '0);
        chk("stop_limit", 16'h01f4, stop_lim);
        chk("start_limit", 16'h07ce, start_lim);
        chk("angle", 16'h0000, {7'h00, angle});
        chk("fly_s", 16'h000f, {8'h00, fly_s});
        wrap_up();
    end
endmodule // press_stop_start_monitor_tb_top
`default_nettype wire
